// ===== hdl/bcs_pkg.sv
// Shared register map, field positions, reset values and timing for the bridge register bank
package bcs_pkg;

  localparam int REG_AW = 9;
  localparam int EV_W = 4;

  // Register indices; the byte address is four times the index
  localparam logic [6:0] IDX_IND_CTL = 7'h48;
  localparam logic [6:0] IDX_IND_ADR0 = 7'h49;
  localparam logic [6:0] IDX_IND_ADR1 = 7'h4a;
  localparam logic [6:0] IDX_DATA0 = 7'h4b;
  localparam logic [6:0] IDX_DATA1 = 7'h4c;
  localparam logic [6:0] IDX_DATA2 = 7'h4d;
  localparam logic [6:0] IDX_DATA3 = 7'h4e;
  localparam logic [6:0] IDX_BR_CTL = 7'h4f;
  localparam logic [6:0] IDX_BR_STS = 7'h50;
  localparam logic [6:0] IDX_IRQ_STS = 7'h60;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h61;

  // Bridge control fields
  localparam int CTL_CEC_SRC_BIT = 4;
  localparam int CTL_CEC_EN_BIT = 3;
  localparam int CTL_CLEAR_BIT = 2;
  localparam int CTL_RELOAD_BIT = 1;
  localparam int CTL_BLOCK_BIT = 0;
  // Bridge status fields
  localparam int STS_SUPPLY_BIT = 7;
  localparam int STS_HDMI_INT_BIT = 6;
  // Indirect access control fields
  localparam int IND_SEL_LSB = 3;
  localparam int IND_AUTOINC_BIT = 2;
  localparam int IND_READ_BIT = 1;
  localparam int IND_EN_BIT = 0;
  // Interrupt event bits
  localparam int EV_RELOAD_DONE = 0;
  localparam int EV_IND_DONE = 1;
  localparam int EV_SUPPLY_CHG = 2;
  localparam int EV_HDMI_INT = 3;

  // Reset values and indirect auto-increment address steps
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] IND_CTL_RST = 5'h00;
  localparam logic [1:0] CEC_CTL_RST = 2'h0;
  localparam logic [1:0] EDID_CTL_RST = 2'h0;
  localparam logic [EV_W-1:0] EV_RST = 4'h0;
  localparam logic [15:0] HDMI_ADDR_STEP = 16'h0004;
  localparam logic [15:0] OTHER_ADDR_STEP = 16'h0001;

  // Timing
  localparam int REF_CLK_HZ = 50_000_000;
  localparam int CEC_CLK_HZ = 32_768;
  localparam int EXT_OSC_HZ = 25_000_000;
  localparam int CEC_DIV_INT = REF_CLK_HZ / CEC_CLK_HZ;
  localparam int CEC_DIV_EXT = EXT_OSC_HZ / CEC_CLK_HZ;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef enum logic [0:0] {
    RL_IDLE = 1'b0,
    RL_BUSY = 1'b1
  } bcs_rl_state_t;

  function automatic logic [REG_AW-1:0] byte_addr(input logic [6:0] idx);
    return {idx, 2'b00};
  endfunction

endpackage

// ===== hdl/bcs_cec_tick.sv
// CEC time base: one-cycle enable at the CEC rate from the system clock or the external oscillator
`timescale 1ns/1ps
module bcs_cec_tick #(
  parameter int INT_DIV = bcs_pkg::CEC_DIV_INT,
  parameter int EXT_DIV = bcs_pkg::CEC_DIV_EXT
) (
  input wire logic ref_clk_i,   // System clock
  input wire logic sys_rst_i,   // Synchronous reset, active high
  input wire logic enable_i,    // Generate ticks while high
  input wire logic src_ext_i,   // 1: count oscillator edges, 0: count system cycles
  input wire logic ext_osc_i,   // External oscillator pin
  output logic tick_o           // One-cycle pulse at the CEC rate
);
  localparam logic [11:0] INT_LIM = 12'(INT_DIV - 1);
  localparam logic [11:0] EXT_LIM = 12'(EXT_DIV - 1);

  logic osc_s1_q, osc_s2_q, osc_s3_q;
  logic [11:0] cnt_q;
  logic [11:0] lim;
  logic step;

  // Oscillator is sampled at twice its rate, so edges are only just seen; accuracy trades for
  // keeping one clock domain
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= ext_osc_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign lim = src_ext_i ? EXT_LIM : INT_LIM;
  assign step = src_ext_i ? (osc_s2_q & ~osc_s3_q) : 1'b1;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !enable_i) begin
      cnt_q <= 12'h000;
      tick_o <= 1'b0;
    end else if (step && cnt_q >= lim) begin
      cnt_q <= 12'h000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= step ? cnt_q + 12'h001 : cnt_q;
      tick_o <= 1'b0;
    end
  end
endmodule

// ===== hdl/bcs_regs.sv
// Bridge control and status register bank with indirect data word, reached over Avalon-MM
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module bcs_regs
  import bcs_pkg::*;
#(
  parameter int CEC_INT_DIV = CEC_DIV_INT,
  parameter int CEC_EXT_DIV = CEC_DIV_EXT
) (
  input wire logic ref_clk_i,                  // System clock, 50 MHz
  input wire logic sys_rst_i,                  // Synchronous reset, active high
  input wire logic [REG_AW-1:0] avs_address_i, // Byte address
  input wire logic avs_read_i,                 // Read request
  input wire logic avs_write_i,                // Write request
  input wire logic [31:0] avs_writedata_i,     // Write data
  input wire logic [3:0] avs_byteenable_i,     // Byte lanes
  output logic [31:0] avs_readdata_o,          // Read data
  output logic avs_waitrequest_o,              // Stall
  output logic ind_rd_req_o,                   // Indirect read pending
  output logic [1:0] ind_sel_o,                // Indirect target select
  output logic [15:0] ind_addr_o,              // Indirect address
  input wire logic ind_rd_ack_i,               // Indirect read done pulse
  input wire logic [31:0] ind_rd_data_i,       // Indirect read result
  output logic sram_reload_start_o,            // Pulse: start SRAM reload
  output logic sram_clear_o,                   // Clear SRAM during this reload
  input wire logic sram_reload_done_i,         // Pulse: reload finished
  output logic ddc_access_block_o,             // Block display channel SRAM access
  input wire logic mode_strap_pin_zero_i,      // Mode strap pin
  input wire logic receive_supply_pin_i,       // Receive +5V detect pin
  input wire logic hdmi_rx_irq_i,              // Receiver interrupt pin
  input wire logic ext_osc_clk_i,              // External 25 MHz oscillator pin
  output logic cec_clock_tick_o,               // CEC rate enable pulse
  output logic cec_clock_source_select_o,      // Selected CEC source
  output logic irq_o                           // Level interrupt
);

  logic ack_q;
  logic req;
  logic wr_en;
  logic [31:0] rd_mux;

  logic [7:0] data_q [4];
  logic [15:0] ind_addr_q;
  logic [4:0] ind_ctl_q;
  logic cec_src_q, cec_en_q;
  logic reload_q, clear_q;
  logic block_q, strap_done_q;
  logic [1:0] strap_cnt_q;
  logic strap_s1_q, strap_s2_q;
  logic sup_s1_q, sup_s2_q, sup_s3_q;
  logic hint_s1_q, hint_s2_q, hint_s3_q;
  logic [EV_W-1:0] ev_sts_q, ev_mask_q, ev_set;
  logic start_q;
  logic ind_done;
  bcs_rl_state_t rl_state_q;

  function automatic logic hit(input logic [REG_AW-1:0] a, input logic [6:0] idx);
    return a == byte_addr(idx);
  endfunction

  // Bus slave: one wait cycle per request, answered on the following edge
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_en = avs_write_i & ack_q & avs_byteenable_i[0];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      hit(avs_address_i, IDX_IND_CTL): rd_mux[4:0] = ind_ctl_q;
      hit(avs_address_i, IDX_IND_ADR0): rd_mux[7:0] = ind_addr_q[7:0];
      hit(avs_address_i, IDX_IND_ADR1): rd_mux[7:0] = ind_addr_q[15:8];
      hit(avs_address_i, IDX_DATA0): rd_mux[7:0] = data_q[0];
      hit(avs_address_i, IDX_DATA1): rd_mux[7:0] = data_q[1];
      hit(avs_address_i, IDX_DATA2): rd_mux[7:0] = data_q[2];
      hit(avs_address_i, IDX_DATA3): rd_mux[7:0] = data_q[3];
      hit(avs_address_i, IDX_BR_CTL): begin
        rd_mux[CTL_CEC_SRC_BIT] = cec_src_q;
        rd_mux[CTL_CEC_EN_BIT] = cec_en_q;
        rd_mux[CTL_CLEAR_BIT] = clear_q;
        rd_mux[CTL_RELOAD_BIT] = reload_q;
        rd_mux[CTL_BLOCK_BIT] = block_q;
      end
      hit(avs_address_i, IDX_BR_STS): begin
        rd_mux[STS_SUPPLY_BIT] = sup_s2_q;
        rd_mux[STS_HDMI_INT_BIT] = hint_s2_q;
      end
      hit(avs_address_i, IDX_IRQ_STS): rd_mux[EV_W-1:0] = ev_sts_q;
      hit(avs_address_i, IDX_IRQ_MASK): rd_mux[EV_W-1:0] = ev_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the wait cycle so it stands at the answering edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Pin synchronisers
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sup_s1_q <= 1'b0;
      sup_s2_q <= 1'b0;
      sup_s3_q <= 1'b0;
      hint_s1_q <= 1'b0;
      hint_s2_q <= 1'b0;
      hint_s3_q <= 1'b0;
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      sup_s1_q <= receive_supply_pin_i;
      sup_s2_q <= sup_s1_q;
      sup_s3_q <= sup_s2_q;
      hint_s1_q <= hdmi_rx_irq_i;
      hint_s2_q <= hint_s1_q;
      hint_s3_q <= hint_s2_q;
      strap_s1_q <= mode_strap_pin_zero_i;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Strap is taken once the synchroniser has filled after reset release
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
      block_q <= 1'b0;
    end else if (!strap_done_q) begin
      if (strap_cnt_q == STRAP_WAIT) begin
        block_q <= strap_s2_q;
        strap_done_q <= 1'b1;
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  assign ddc_access_block_o = block_q;

  // Indirect data word; a completed read overrides a same-cycle software write
  assign ind_done = ind_rd_ack_i & ind_ctl_q[IND_READ_BIT];

  generate
    for (genvar b = 0; b < 4; b++) begin : g_data
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          data_q[b] <= BYTE_RST;
        end else if (ind_done) begin
          data_q[b] <= ind_rd_data_i[8*b +: 8];
        end else if (wr_en && hit(avs_address_i, 7'(IDX_DATA0 + 7'(b)))) begin
          data_q[b] <= avs_writedata_i[7:0];
        end
      end
    end
  endgenerate

  // Indirect control and address
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ind_ctl_q <= IND_CTL_RST;
      ind_addr_q <= 16'h0000;
    end else begin
      if (ind_done) begin
        ind_ctl_q[IND_READ_BIT] <= 1'b0;
        if (ind_ctl_q[IND_AUTOINC_BIT]) begin
          ind_addr_q <= ind_addr_q + ((ind_ctl_q[4:3] == 2'h0) ? HDMI_ADDR_STEP : OTHER_ADDR_STEP);
        end
      end
      if (wr_en && hit(avs_address_i, IDX_IND_CTL)) begin
        ind_ctl_q <= avs_writedata_i[4:0];
      end
      if (wr_en && hit(avs_address_i, IDX_IND_ADR0)) begin
        ind_addr_q[7:0] <= avs_writedata_i[7:0];
      end
      if (wr_en && hit(avs_address_i, IDX_IND_ADR1)) begin
        ind_addr_q[15:8] <= avs_writedata_i[7:0];
      end
    end
  end

  // Request only while the interface is enabled; address must be set before the start bit
  assign ind_rd_req_o = ind_ctl_q[IND_READ_BIT] & ind_ctl_q[IND_EN_BIT];
  assign ind_sel_o = ind_ctl_q[IND_SEL_LSB +: 2];
  assign ind_addr_o = ind_addr_q;

  // CEC control bits
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      {cec_src_q, cec_en_q} <= CEC_CTL_RST;
    end else if (wr_en && hit(avs_address_i, IDX_BR_CTL)) begin
      cec_src_q <= avs_writedata_i[CTL_CEC_SRC_BIT];
      cec_en_q <= avs_writedata_i[CTL_CEC_EN_BIT];
    end
  end

  assign cec_clock_source_select_o = cec_src_q;

  bcs_cec_tick #(
    .INT_DIV(CEC_INT_DIV),
    .EXT_DIV(CEC_EXT_DIV)
  ) u_cec_tick (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(cec_en_q),
    .src_ext_i(cec_src_q),
    .ext_osc_i(ext_osc_clk_i),
    .tick_o(cec_clock_tick_o)
  );

  // SRAM reload sequence; the bits are held by hardware while a reload runs
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rl_state_q <= RL_IDLE;
      {clear_q, reload_q} <= EDID_CTL_RST;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (rl_state_q)
        RL_IDLE: begin
          if (wr_en && hit(avs_address_i, IDX_BR_CTL)) begin
            clear_q <= avs_writedata_i[CTL_CLEAR_BIT];
            reload_q <= avs_writedata_i[CTL_RELOAD_BIT];
            if (avs_writedata_i[CTL_RELOAD_BIT]) begin
              start_q <= 1'b1;
              rl_state_q <= RL_BUSY;
            end
          end
        end
        RL_BUSY: begin
          if (sram_reload_done_i) begin
            clear_q <= 1'b0;
            reload_q <= 1'b0;
            rl_state_q <= RL_IDLE;
          end
        end
        default: rl_state_q <= RL_IDLE;
      endcase
    end
  end

  assign sram_reload_start_o = start_q;
  // A clear bit written without the reload bit never reaches the SRAM
  assign sram_clear_o = clear_q & reload_q & (rl_state_q == RL_BUSY);

  // Interrupt events; a new event wins over a same-cycle write-one-to-clear
  assign ev_set[EV_RELOAD_DONE] = sram_reload_done_i & (rl_state_q == RL_BUSY);
  assign ev_set[EV_IND_DONE] = ind_done;
  assign ev_set[EV_SUPPLY_CHG] = sup_s2_q ^ sup_s3_q;
  assign ev_set[EV_HDMI_INT] = hint_s2_q & ~hint_s3_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ev_sts_q <= EV_RST;
    end else if (wr_en && hit(avs_address_i, IDX_IRQ_STS)) begin
      ev_sts_q <= (ev_sts_q & ~avs_writedata_i[EV_W-1:0]) | ev_set;
    end else begin
      ev_sts_q <= ev_sts_q | ev_set;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ev_mask_q <= EV_RST;
    end else if (wr_en && hit(avs_address_i, IDX_IRQ_MASK)) begin
      ev_mask_q <= avs_writedata_i[EV_W-1:0];
    end
  end

  assign irq_o = |(ev_sts_q & ev_mask_q);

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_status_read;
    avs_read_i && !ack_q && hit(avs_address_i, IDX_BR_STS);
  endsequence

  sequence s_reload_started;
    start_q ##1 (rl_state_q == RL_BUSY);
  endsequence

  sequence s_reload_done;
    (rl_state_q == RL_BUSY) && sram_reload_done_i;
  endsequence

  chk_bus_one_wait: assert property ( // bus
    (req && !ack_q) |-> avs_waitrequest_o ##1 (!avs_waitrequest_o && req))
    else $error("Request not answered after exactly one wait cycle");

  chk_cec_tick_gate: assert property (
    cec_clock_tick_o |-> $past(cec_en_q))
    else $error("CEC tick produced while CEC clock disabled");

  chk_clear_needs_reload: assert property (
    sram_clear_o |-> (reload_q && rl_state_q == RL_BUSY))
    else $error("SRAM clear driven without a reload in progress");

  chk_reload_self_clear: assert property (
    s_reload_done |=> (!reload_q && !clear_q && rl_state_q == RL_IDLE))
    else $error("Reload and clear bits not cleared after completion");

  chk_reload_single_start: assert property (
    s_reload_started |-> (!start_q && reload_q))
    else $error("Reload start pulse longer than one cycle");

  chk_block_stable: assert property (
    (strap_done_q && $past(strap_done_q)) |-> $stable(block_q) && ddc_access_block_o == block_q)
    else $error("Strap-loaded block bit changed after capture");

  chk_supply_read: assert property (
    s_status_read |=> avs_readdata_o[STS_SUPPLY_BIT] == $past(sup_s2_q))
    else $error("Status bit 7 does not match supply pin");

  chk_hdmi_int_read: assert property (
    s_status_read |=> avs_readdata_o[STS_HDMI_INT_BIT] == $past(hint_s2_q) &&
      avs_readdata_o[5:0] == 6'h00)
    else $error("Status bit 6 does not match receiver interrupt");

  chk_data_write: assert property (
    (wr_en && hit(avs_address_i, IDX_DATA2) && !ind_done) |=>
      data_q[2] == $past(avs_writedata_i[7:0]))
    else $error("Data byte 2 not updated by write");

  chk_ind_read_done: assert property (
    ind_done && !(wr_en && hit(avs_address_i, IDX_IND_CTL)) |=>
      !ind_rd_req_o && {data_q[3], data_q[2], data_q[1], data_q[0]} == $past(ind_rd_data_i))
    else $error("Indirect read result not stored or start bit not cleared");

  chk_ro_ignored: assert property (
    (wr_en && hit(avs_address_i, IDX_BR_STS)) |=> $stable(block_q) && $stable(cec_en_q) &&
      $stable(ev_mask_q))
    else $error("Write to read-only status had a side effect");

endmodule

// ===== dv/bridge_control_status_regs_tb.sv
// Self-checking bench for the bridge control and status register bank
`timescale 1ns/1ps
module bridge_control_status_regs_tb;
  import bcs_pkg::*;
  // Short CEC dividers keep the tick checks brief
  localparam int INT_DIV = 4;
  localparam int EXT_DIV = 2;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [REG_AW-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = '0;
  logic ind_rd_ack_i = 1'b0;
  logic [31:0] ind_rd_data_i = '0;
  logic sram_reload_done_i = 1'b0;
  logic mode_strap_pin_zero_i = 1'b1;
  logic receive_supply_pin_i = 1'b0;
  logic hdmi_rx_irq_i = 1'b0;
  logic ext_osc_clk_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, ind_rd_req_o, sram_reload_start_o, sram_clear_o;
  logic ddc_access_block_o, cec_clock_tick_o, cec_clock_source_select_o, irq_o;
  logic [1:0] ind_sel_o;
  logic [15:0] ind_addr_o;
  logic [1:0] osc_div = 2'h0;
  logic [31:0] rd;
  int err_count = 0;
  int checked = 0;
  int start_cnt = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  bcs_regs #(.CEC_INT_DIV(INT_DIV), .CEC_EXT_DIV(EXT_DIV)) DUT (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ind_rd_req_o(ind_rd_req_o), .ind_sel_o(ind_sel_o),
    .ind_addr_o(ind_addr_o), .ind_rd_ack_i(ind_rd_ack_i), .ind_rd_data_i(ind_rd_data_i),
    .sram_reload_start_o(sram_reload_start_o), .sram_clear_o(sram_clear_o),
    .sram_reload_done_i(sram_reload_done_i), .ddc_access_block_o(ddc_access_block_o),
    .mode_strap_pin_zero_i(mode_strap_pin_zero_i), .receive_supply_pin_i(receive_supply_pin_i),
    .hdmi_rx_irq_i(hdmi_rx_irq_i), .ext_osc_clk_i(ext_osc_clk_i),
    .cec_clock_tick_o(cec_clock_tick_o), .cec_clock_source_select_o(cec_clock_source_select_o),
    .irq_o(irq_o));

  // Oscillator stand-in runs free at a quarter of the system rate
  always @(posedge ref_clk_i) begin
    osc_div <= osc_div + 2'h1;
    ext_osc_clk_i <= osc_div[1];
    if (sram_reload_start_o === 1'b1) start_cnt <= start_cnt + 1;
  end

  function automatic logic [REG_AW-1:0] ad(input logic [6:0] idx);
    return {idx, 2'b00};
  endfunction
  function automatic logic [31:0] exp_ctl(input logic src, en, clr, rl, blk);
    return {27'h0, src, en, clr, rl, blk};
  endfunction
  function automatic logic [31:0] exp_sts(input logic sup, hi);
    return {24'h0, sup, hi, 6'h00};
  endfunction
  function automatic logic [15:0] next_addr(input logic [1:0] sel, input logic [15:0] a);
    return a + ((sel == 2'h0) ? 16'h0004 : 16'h0001);
  endfunction
  function automatic int exp_ticks(input int src, input int cyc);
    return (src != 0) ? cyc / (4 * EXT_DIV) : cyc / INT_DIV;
  endfunction

  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // One Avalon transfer; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [REG_AW-1:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0, "bus never answered");
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rdr(input logic [REG_AW-1:0] a);
    bus(1'b0, a, 8'h00, 4'h0);
  endtask

  task automatic rst(input logic strap);
    sys_rst_i <= 1'b1;
    mode_strap_pin_zero_i <= strap;
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge ref_clk_i);
  endtask

  task automatic count_ticks(input int cyc, output int cnt);
    cnt = 0;
    repeat (cyc) begin
      @(posedge ref_clk_i);
      if (cec_clock_tick_o === 1'b1) cnt++;
    end
  endtask

  task automatic done_pulse();
    sram_reload_done_i <= 1'b1;
    @(posedge ref_clk_i);
    sram_reload_done_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    int n, e, s0;
    logic [7:0] d2, d3;
    logic [31:0] dd;
    logic [15:0] ia;
    void'($urandom(32'hccaa));
    rst(1'b1);
    rdr(ad(IDX_DATA2)); chk(rd, 32'h0, "data2 reset");
    rdr(ad(IDX_DATA3)); chk(rd, 32'h0, "data3 reset");
    rdr(ad(IDX_DATA0)); chk(rd, 32'h0, "data0 reset");
    rdr(ad(IDX_BR_CTL)); chk(rd, exp_ctl(0, 0, 0, 0, 1), "control reset");
    chk({31'h0, ddc_access_block_o}, 32'h1, "block output high");
    rdr(ad(IDX_BR_STS)); chk(rd, exp_sts(0, 0), "status reset");
    // Random data bytes; a write with lane 0 off must not land
    repeat (8) begin
      d2 = 8'($urandom);
      d3 = 8'($urandom);
      wr(ad(IDX_DATA2), d2);
      wr(ad(IDX_DATA3), d3);
      bus(1'b1, ad(IDX_DATA2), ~d2, 4'h0);
      rdr(ad(IDX_DATA2)); chk(rd, {24'h0, d2}, "data2 readback");
      rdr(ad(IDX_DATA3)); chk(rd, {24'h0, d3}, "data3 readback");
    end
    rdr(ad(7'h7f)); chk(rd, 32'h0, "unmapped read");
    wr(ad(IDX_BR_CTL), 8'h00);
    rdr(ad(IDX_BR_CTL)); chk(rd, exp_ctl(0, 0, 0, 0, 1), "strap bit written");
    // CEC time base: silent while disabled, rate follows the source
    count_ticks(40, n); chk(32'(n), 32'h0, "ticks while disabled");
    for (int src = 0; src < 2; src++) begin
      wr(ad(IDX_BR_CTL), {3'h0, src[0], 1'b1, 3'h0});
      chk({31'h0, cec_clock_source_select_o}, 32'(src), "source output");
      repeat (8) @(posedge ref_clk_i);
      count_ticks(80, n);
      e = exp_ticks(src, 80);
      chk({31'h0, (n >= e - 1 && n <= e + 1)}, 32'h1, "tick rate");
    end
    wr(ad(IDX_BR_CTL), 8'h00);
    repeat (4) @(posedge ref_clk_i);
    count_ticks(40, n); chk(32'(n), 32'h0, "ticks after disable");
    // Reload alone, clear alone, then both together
    s0 = start_cnt;
    wr(ad(IDX_BR_CTL), 8'h02);
    repeat (2) @(posedge ref_clk_i);
    chk(32'(start_cnt - s0), 32'h1, "reload start");
    chk({31'h0, sram_clear_o}, 32'h0, "clear without clear bit");
    rdr(ad(IDX_BR_CTL)); chk(rd, exp_ctl(0, 0, 0, 1, 1), "reload busy");
    done_pulse();
    rdr(ad(IDX_BR_CTL)); chk(rd, exp_ctl(0, 0, 0, 0, 1), "reload self clear");
    wr(ad(IDX_BR_CTL), 8'h04);
    repeat (4) @(posedge ref_clk_i);
    chk(32'(start_cnt - s0), 32'h1, "clear bit alone started");
    chk({31'h0, sram_clear_o}, 32'h0, "clear bit alone cleared");
    wr(ad(IDX_BR_CTL), 8'h06);
    repeat (4) @(posedge ref_clk_i);
    chk(32'(start_cnt - s0), 32'h2, "clear and reload start");
    chk({31'h0, sram_clear_o}, 32'h1, "clear during reload");
    done_pulse();
    chk({31'h0, sram_clear_o}, 32'h0, "clear after done");
    rdr(ad(IDX_BR_CTL)); chk(rd, exp_ctl(0, 0, 0, 0, 1), "both bits self clear");
    // Status pins pass through the synchronisers
    for (int k = 0; k < 4; k++) begin
      receive_supply_pin_i <= k[0];
      hdmi_rx_irq_i <= k[1];
      repeat (4) @(posedge ref_clk_i);
      rdr(ad(IDX_BR_STS)); chk(rd, exp_sts(k[0], k[1]), "status pins");
    end
    wr(ad(IDX_BR_STS), 8'hff);
    rdr(ad(IDX_BR_STS)); chk(rd, exp_sts(1, 1), "status written");
    // Indirect read with auto-increment, and its interrupt
    wr(ad(IDX_IRQ_STS), 8'h0f);
    wr(ad(IDX_IRQ_MASK), 8'h02);
    chk({31'h0, irq_o}, 32'h0, "irq after clear");
    ia = 16'($urandom);
    dd = $urandom;
    wr(ad(IDX_IND_ADR0), ia[7:0]);
    wr(ad(IDX_IND_ADR1), ia[15:8]);
    wr(ad(IDX_IND_CTL), 8'h07);
    n = 0;
    while (ind_rd_req_o !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk({31'h0, ind_rd_req_o}, 32'h1, "indirect request");
    chk({16'h0, ind_addr_o}, {16'h0, ia}, "indirect address");
    chk({30'h0, ind_sel_o}, 32'h0, "indirect select");
    ind_rd_ack_i <= 1'b1;
    ind_rd_data_i <= dd;
    @(posedge ref_clk_i);
    ind_rd_ack_i <= 1'b0;
    ind_rd_data_i <= ~dd;
    repeat (2) @(posedge ref_clk_i);
    chk({31'h0, ind_rd_req_o}, 32'h0, "request after ack");
    chk({16'h0, ind_addr_o}, {16'h0, next_addr(2'h0, ia)}, "auto increment");
    rdr(ad(IDX_IND_CTL)); chk(rd, 32'h5, "start bit cleared");
    for (int b = 0; b < 4; b++) begin
      rdr(ad(IDX_DATA0 + 7'(b))); chk(rd, {24'h0, dd[8*b +: 8]}, "read result");
    end
    chk({31'h0, irq_o}, 32'h1, "irq on read done");
    wr(ad(IDX_IRQ_MASK), 8'h00);
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    wr(ad(IDX_IRQ_MASK), 8'h02);
    wr(ad(IDX_IRQ_STS), 8'h02);
    chk({31'h0, irq_o}, 32'h0, "irq after write one clear");
    rdr(ad(IDX_IRQ_STS)); chk(rd & 32'h2, 32'h0, "status bit cleared");
    // Non-receiver target steps the address by one
    wr(ad(IDX_IND_CTL), 8'h0f);
    chk({30'h0, ind_sel_o}, 32'h1, "indirect select one");
    ind_rd_ack_i <= 1'b1;
    ind_rd_data_i <= dd;
    @(posedge ref_clk_i);
    ind_rd_ack_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk({16'h0, ind_addr_o}, {16'h0, next_addr(2'h1, next_addr(2'h0, ia))}, "step one");
    // Second reset with the strap low
    rst(1'b0);
    rdr(ad(IDX_BR_CTL)); chk(rd, exp_ctl(0, 0, 0, 0, 0), "strap low");
    chk({31'h0, ddc_access_block_o}, 32'h0, "block output low");
    rdr(ad(IDX_DATA2)); chk(rd, 32'h0, "data2 after reset");
    tally_and_finish();
  end
endmodule
